//--- design/pdc_pkg.sv
// shared constants and types of the prescaled down-counter
package pdc_pkg;

  // ---------------------------------------------------------------
  // register map (index, byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int IDX_W = 10;
  localparam logic [IDX_W-1:0] IDX_PRESCALER_COUNT = 10'h0d2;
  localparam logic [IDX_W-1:0] IDX_MAIN_COUNT = 10'h0d3;
  localparam logic [IDX_W-1:0] IDX_COUNT_STATUS_CONTROL = 10'h0d4;
  localparam logic [IDX_W-1:0] IDX_UNMAPPED = 10'h3ff;

  // ---------------------------------------------------------------
  // reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [6:0] PRESCALER_RESET = 7'h7f;
  localparam logic [7:0] MAIN_COUNT_RESET = 8'hff;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int FLAG_BIT = 7;
  localparam int IEN_BIT = 6;
  localparam int DIR_BIT = 5;
  localparam int DOUT_BIT = 4;
  localparam int RUN_BIT = 3;
  localparam int TAP_LSB = 0;

  // ---------------------------------------------------------------
  // timing: internal clock divided by twelve
  // ---------------------------------------------------------------
  localparam int DIV_RATIO = 12;
  localparam logic [3:0] DIV_LAST = 4'(DIV_RATIO - 1);

  // ---------------------------------------------------------------
  // bus constants
  // ---------------------------------------------------------------
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [19:0] HADDR_HIGH_ZERO = 20'h0_0000;

  // pin role selected by direction and data-out bits
  typedef enum logic [2:0]
  {
    PDC_MODE_EVENT = 3'b001,
    PDC_MODE_GATED = 3'b010,
    PDC_MODE_OUTPUT = 3'b100
  } pdc_mode_t;

  // state of the counting core
  typedef struct packed
  {
    logic flag;
    logic ien;
    logic dir;
    logic dout;
    logic run;
    logic [2:0] tap;
    logic [6:0] psc;
    logic [7:0] cnt;
    logic [3:0] div;
    logic pin_out;
    logic pin_oe;
    logic irq;
    logic wake;
  } pdc_core_t;

  // state of the bus slave
  typedef struct packed
  {
    logic [IDX_W-1:0] idx;
    logic wr_pend;
    logic rd_pend;
    logic ready;
    logic [31:0] rdata;
  } pdc_ahb_t;

endpackage

//--- design/pdc_regbus_if.sv
// register access path between the bus slave and the counting core
`timescale 1ns/1ps
interface pdc_regbus_if;
  logic wr_en;
  logic [pdc_pkg::IDX_W-1:0] wr_idx;
  logic [7:0] wr_data;
  logic [pdc_pkg::IDX_W-1:0] rd_idx;
  logic [7:0] rd_data;

  modport bus (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport regs (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface

//--- design/pdc_pin_sync.sv
// two-stage synchroniser and rising-edge detect for the count pin
`timescale 1ns/1ps
module pdc_pin_sync
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin_in,
  output logic pin_level,
  output logic pin_rise
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  // first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // one pulse per synchronised rising edge
  assign pin_level = sync_ff;
  assign pin_rise = sync_ff & ~prev_ff;
endmodule // pdc_pin_sync

//--- design/pdc_ahb_slave.sv
// ahb-lite slave, one wait state on reads, none on writes
`timescale 1ns/1ps
module pdc_ahb_slave
  import pdc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  pdc_regbus_if.bus regbus
);
  pdc_ahb_t st_ff;
  pdc_ahb_t nxt_st;
  logic accept;

  // ---------------------------------------------------------------
  // address phase capture and data phase completion
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    accept = hsel && htrans[1] && hready && (hsize == HSIZE_WORD);
    nxt_st.wr_pend = 1'b0;
    if (st_ff.rd_pend)
    begin
      nxt_st.rdata = {24'h00_0000, regbus.rd_data};
      nxt_st.rd_pend = 1'b0;
      nxt_st.ready = 1'b1;
    end
    else if (accept)
    begin
      nxt_st.idx = (haddr[31:12] == HADDR_HIGH_ZERO) ? haddr[11:2] : IDX_UNMAPPED;
      nxt_st.wr_pend = hwrite;
      nxt_st.rd_pend = !hwrite;
      nxt_st.ready = hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff <= '{idx: IDX_UNMAPPED, wr_pend: 1'b0, rd_pend: 1'b0, ready: 1'b1, rdata: 32'h0000_0000};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // write strobe stands during the data phase
  assign regbus.wr_en = st_ff.wr_pend;
  assign regbus.wr_idx = st_ff.idx;
  assign regbus.wr_data = hwdata[7:0];
  assign regbus.rd_idx = st_ff.idx;
  assign hreadyout = st_ff.ready;
  assign hresp = 1'b0; // always okay
  assign hrdata = st_ff.rdata;
endmodule // pdc_ahb_slave

//--- design/pdc_counter.sv
// prescaled down-counter core with its bus slave and pin synchroniser
`timescale 1ns/1ps
// Operation
// [RULE1] gated mode: divided clock counts while pin high
// [RULE2] event mode: count on each pin rising edge
// [RULE3] output mode: divided clock only, pin ignored
// [RULE4] flag rise latches data-out onto pin
// [RULE5] direction set drives pin push-pull
// [RULE6] wait mode: counting continues, irq wakes
// [RULE7] stop freezes all except event mode
// [RULE8] irq equals flag and enable
// [RULE9] prescaler read: top bit zero, live value
// [RULE10] underflow 00 to ff sets flag
// [RULE11] flag cleared by software only
// [RULE12] run low holds prescaler 7f, counter stops
// [RULE13] tap select divides by two to n
// [RULE14] data-out chooses gated or event input
// [RULE15] direction zero input, one output
// [RULE16] prescaler and counter reload on wrap
// [RULE17] writing zero or flag bit sets flag
// [RULE18] counter write beats coinciding underflow
// [RULE19] enabled irq also wakes from stop
// [RULE20] pin synchronised, one count per edge
module pdc_counter
  import pdc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic count_pin_in,
  output logic count_pin_out,
  output logic count_pin_oe,
  input wire logic wait_mode,
  input wire logic stop_mode,
  output logic count_irq,
  output logic wake_request
);
  import pdc_pkg::*;

  pdc_core_t st_ff;
  pdc_core_t nxt_st;
  pdc_mode_t mode;
  logic pin_level;
  logic pin_rise;
  logic tick12;
  logic src;
  logic frozen;
  logic psc_tick;
  logic [6:0] tap_mask;
  logic sw_wr;
  logic cw_wr;
  logic pw_wr;
  logic uf;
  logic [7:0] rd_val;

  pdc_regbus_if regbus ();

  // ---------------------------------------------------------------
  // bus slave and pin synchroniser
  // ---------------------------------------------------------------
  pdc_ahb_slave u_ahb
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .regbus(regbus.bus)
  );

  pdc_pin_sync u_sync
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(count_pin_in), // RULE20
    .pin_level(pin_level),
    .pin_rise(pin_rise)
  );

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    sw_wr = regbus.wr_en && (regbus.wr_idx == IDX_COUNT_STATUS_CONTROL);
    cw_wr = regbus.wr_en && (regbus.wr_idx == IDX_MAIN_COUNT);
    pw_wr = regbus.wr_en && (regbus.wr_idx == IDX_PRESCALER_COUNT);
    uf = 1'b0;
    // pin role from direction and data-out
    if (st_ff.dir) // RULE15
    begin
      mode = PDC_MODE_OUTPUT;
    end
    else
    begin
      mode = st_ff.dout ? PDC_MODE_GATED : PDC_MODE_EVENT; // RULE14
    end
    // divide-by-twelve timebase, stopped with the core in stop mode
    frozen = stop_mode && (mode != PDC_MODE_EVENT); // RULE7
    tick12 = (st_ff.div == DIV_LAST);
    if (!frozen)
    begin
      nxt_st.div = tick12 ? 4'h0 : 4'(st_ff.div + 4'h1);
    end
    // prescaler clock source; wait mode changes nothing
    src = 1'b0;
    unique case (mode)
      PDC_MODE_EVENT: src = pin_rise; // RULE2
      PDC_MODE_GATED: src = tick12 && pin_level; // RULE1
      PDC_MODE_OUTPUT: src = tick12; // RULE3
    endcase
    src = src && !frozen && st_ff.run; // RULE6
    // tap: counter steps when the low n prescaler bits are zero
    tap_mask = 7'((8'h01 << st_ff.tap) - 8'h01); // RULE13
    psc_tick = src && ((st_ff.psc & tap_mask) == 7'h00);
    // status and control fields
    if (sw_wr)
    begin
      nxt_st.ien = regbus.wr_data[IEN_BIT];
      nxt_st.dir = regbus.wr_data[DIR_BIT];
      nxt_st.dout = regbus.wr_data[DOUT_BIT];
      nxt_st.run = regbus.wr_data[RUN_BIT];
      nxt_st.tap = regbus.wr_data[TAP_LSB+:3];
    end
    // prescaler: held at 7f when not running, writable when running
    if (!nxt_st.run)
    begin
      nxt_st.psc = PRESCALER_RESET; // RULE12
    end
    else if (pw_wr)
    begin
      nxt_st.psc = regbus.wr_data[6:0];
    end
    else if (src)
    begin
      nxt_st.psc = (st_ff.psc == 7'h00) ? PRESCALER_RESET : 7'(st_ff.psc - 7'h01); // RULE16
    end
    // main counter: a write wins over a decrement
    if (cw_wr)
    begin
      nxt_st.cnt = regbus.wr_data; // RULE18
    end
    else if (psc_tick && nxt_st.run)
    begin
      uf = (st_ff.cnt == 8'h00); // RULE10
      nxt_st.cnt = 8'(st_ff.cnt - 8'h01); // RULE16
    end
    // flag: hardware only sets, any set wins over a software clear
    nxt_st.flag = uf || (cw_wr && (regbus.wr_data == 8'h00)) // RULE17
      || (sw_wr ? regbus.wr_data[FLAG_BIT] : st_ff.flag); // RULE11
    // latch data-out on the rising flag
    if (!st_ff.flag && nxt_st.flag)
    begin
      nxt_st.pin_out = st_ff.dout; // RULE4
    end
    // pin drive follows direction, requests follow flag and enable
    nxt_st.pin_oe = nxt_st.dir; // RULE5
    nxt_st.irq = nxt_st.flag && nxt_st.ien; // RULE8
    nxt_st.wake = nxt_st.flag && nxt_st.ien; // RULE19
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff <= '{flag: 1'b0, ien: 1'b0, dir: 1'b0, dout: 1'b0, run: 1'b0, tap: 3'h0,
                 psc: PRESCALER_RESET, cnt: MAIN_COUNT_RESET, div: 4'h0,
                 pin_out: 1'b0, pin_oe: 1'b0, irq: 1'b0, wake: 1'b0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb
  begin
    rd_val = 8'h00;
    if (regbus.rd_idx == IDX_PRESCALER_COUNT)
    begin
      rd_val = {1'b0, st_ff.psc}; // RULE9
    end
    else if (regbus.rd_idx == IDX_MAIN_COUNT)
    begin
      rd_val = st_ff.cnt;
    end
    else if (regbus.rd_idx == IDX_COUNT_STATUS_CONTROL)
    begin
      rd_val = {st_ff.flag, st_ff.ien, st_ff.dir, st_ff.dout, st_ff.run, st_ff.tap};
    end
  end

  assign regbus.rd_data = rd_val;
  assign count_pin_out = st_ff.pin_out;
  assign count_pin_oe = st_ff.pin_oe;
  assign count_irq = st_ff.irq;
  assign wake_request = st_ff.wake;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // gated mode: no step while the pin is low
  gated_hold_a: assert property (mode == PDC_MODE_GATED && !pin_level && st_ff.run && !regbus.wr_en // RULE1
    |=> $stable(st_ff.psc)) else $error("gated prescaler moved with pin low");

  // event mode: every synchronised edge steps
  event_edge_a: assert property (mode == PDC_MODE_EVENT && pin_rise && st_ff.run && !regbus.wr_en // RULE2
    |=> !$stable(st_ff.psc)) else $error("event edge did not count");

  // output mode: steps only on the divided tick
  output_src_a: assert property (mode == PDC_MODE_OUTPUT && !tick12 && !regbus.wr_en // RULE3
    |=> $stable(st_ff.psc)) else $error("output mode counted off tick");

  // timebase wraps after its last count
  div_wrap_a: assert property (tick12 && !frozen |=> st_ff.div == 4'h0) // RULE3
    else $error("timebase did not wrap");

  // wait mode leaves counting running
  wait_count_a: assert property (wait_mode && src && !regbus.wr_en |=> !$stable(st_ff.psc)) // RULE6
    else $error("prescaler stalled in wait mode");

  // ---------------------------------------------------------------
  // assertions: pin, stop, flag, prescaler and tap
  // ---------------------------------------------------------------

  // data-out captured on the flag rise
  dout_latch_a: assert property ($rose(st_ff.flag) |-> count_pin_out == $past(st_ff.dout)) // RULE4
    else $error("data-out not latched on flag rise");

  // pin value moves only on a flag rise
  pin_hold_a: assert property (!$rose(st_ff.flag) |-> $stable(count_pin_out)) // RULE4
    else $error("pin output moved without flag rise");

  // pin enable follows a direction write
  pin_drive_a: assert property (sw_wr |=> count_pin_oe == $past(regbus.wr_data[DIR_BIT])) // RULE5
    else $error("pin enable does not follow direction");

  // pin enable always mirrors the direction bit
  oe_follow_a: assert property (count_pin_oe == st_ff.dir) // RULE15
    else $error("pin enable differs from direction");

  // stop mode freezes counting outside event mode
  stop_freeze_a: assert property (frozen && !regbus.wr_en |=> $stable(st_ff.cnt) && $stable(st_ff.psc)) // RULE7
    else $error("counter moved in stop mode");

  // event mode keeps counting in stop mode
  event_stop_a: assert property (stop_mode && mode == PDC_MODE_EVENT && pin_rise && st_ff.run // RULE7
    && !regbus.wr_en |=> !$stable(st_ff.psc)) else $error("event count stopped in stop mode");

  // request and wake equal flag and enable
  irq_level_a: assert property (count_irq == (st_ff.flag && st_ff.ien) && wake_request == count_irq) // RULE8
    else $error("irq or wake mismatch");

  // prescaler read shows zero top bit
  psc_read_a: assert property (regbus.rd_idx == IDX_PRESCALER_COUNT // RULE9
    |-> regbus.rd_data == {1'b0, st_ff.psc}) else $error("prescaler read wrong");

  // decrement from zero wraps and flags
  underflow_set_a: assert property (psc_tick && st_ff.run && st_ff.cnt == 8'h00 && !regbus.wr_en // RULE10
    |=> st_ff.flag && st_ff.cnt == MAIN_COUNT_RESET) else $error("underflow missed");

  // counter write stores its value and raises no underflow
  cnt_write_a: assert property (cw_wr && regbus.wr_data != 8'h00 // RULE18
    |=> st_ff.cnt == $past(regbus.wr_data) && $stable(st_ff.flag)) else $error("counter write lost or flagged");

  // flag falls only by a software write of zero
  flag_clear_a: assert property ($fell(st_ff.flag) |-> $past(sw_wr) && !$past(regbus.wr_data[FLAG_BIT])) // RULE11
    else $error("flag cleared without software");

  // writing zero to the counter sets the flag
  zero_write_a: assert property (cw_wr && regbus.wr_data == 8'h00 |=> st_ff.flag) // RULE17
    else $error("zero write did not set flag");

  // prescaler parked while not running
  run_hold_a: assert property (!st_ff.run |-> st_ff.psc == PRESCALER_RESET) // RULE12
    else $error("prescaler not held while stopped");

  // counter holds between tap points
  tap_skip_a: assert property (src && (st_ff.psc & tap_mask) != 7'h00 && !regbus.wr_en // RULE13
    |=> $stable(st_ff.cnt)) else $error("counter stepped between taps");
endmodule // pdc_counter

//--- verif/pdc_pin_source.sv
// count pin source model: pulse trains or a held level
`timescale 1ns/1ps
module pdc_pin_source
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic [7:0] pulses,
  input wire logic hold_high,
  input wire logic pin_oe,
  input wire logic pin_out,
  output logic pin_line,
  output logic busy
);
  logic [8:0] left_ff;
  logic [1:0] ph_ff;
  // half periods of three cycles, high half first
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      left_ff <= 9'h000;
      ph_ff <= 2'h0;
    end
    else if (start)
    begin
      left_ff <= {pulses, 1'b0};
      ph_ff <= 2'h0;
    end
    else if (left_ff != 9'h000)
    begin
      ph_ff <= (ph_ff == 2'h2) ? 2'h0 : ph_ff + 2'h1;
      if (ph_ff == 2'h2) left_ff <= left_ff - 9'h001;
    end
  end
  assign busy = (left_ff != 9'h000);
  // block output wins while enabled, else source level
  assign pin_line = pin_oe ? pin_out : (busy ? !left_ff[0] : hold_high);
endmodule // pdc_pin_source

//--- verif/tb.sv
// self-checking bench of the prescaled down-counter
`timescale 1ns/1ps
module tb;
  import pdc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout, hresp, pin_out, pin_oe, irq, wake, pin_line, busy;
  logic wait_mode = 1'b0;
  logic stop_mode = 1'b0;
  logic start = 1'b0;
  logic hold_high = 1'b0;
  logic [7:0] pulses = 8'h00;
  logic [31:0] v;
  int fail_count = 0;
  int checks_done = 0;
  always #2.5 hclk = ~hclk;
  pdc_counter dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .count_pin_in(pin_line), .count_pin_out(pin_out),
    .count_pin_oe(pin_oe), .wait_mode(wait_mode), .stop_mode(stop_mode), .count_irq(irq),
    .wake_request(wake));
  pdc_pin_source src (.hclk(hclk), .hresetn(hresetn), .start(start), .pulses(pulses),
    .hold_high(hold_high), .pin_oe(pin_oe), .pin_out(pin_out), .pin_line(pin_line), .busy(busy));
  // ---------------------------------------------------------------
  // compares, bus cycles, pin pulses
  // ---------------------------------------------------------------
  task automatic test_done();
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checks_done++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  // sample at the falling edge, the value seen by the next rising edge
  task automatic wait_rdy(output logic [31:0] d);
    logic r;
    logic e;
    do
    begin
      @(negedge hclk);
      r = hreadyout;
      e = hresp;
      d = hrdata;
      @(posedge hclk);
    end
    while (r !== 1'b1);
    chk({31'h0000_0000, e}, 32'h0000_0000); // okay response
  endtask
  task automatic xfer(input logic wr, input logic [9:0] idx, input logic [7:0] wd, output logic [31:0] rd);
    logic [31:0] d;
    hsel <= 1'b1;
    haddr <= {HADDR_HIGH_ZERO, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy(d);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, wd};
    wait_rdy(rd);
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    xfer(1'b1, idx, wd, d);
  endtask
  task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    xfer(1'b0, idx, 8'h00, d);
    chk(d, {24'h00_0000, exp});
  endtask
  // pin out, pin enable, irq, wake
  task automatic pins(input logic [3:0] exp);
    @(negedge hclk);
    chk({28'h000_0000, pin_out, pin_oe, irq, wake}, {28'h000_0000, exp});
    @(posedge hclk);
  endtask
  task automatic pulse(input logic [7:0] n);
    pulses <= n;
    start <= 1'b1;
    @(posedge hclk);
    start <= 1'b0;
    do @(negedge hclk); while (busy !== 1'b0);
    repeat (4) @(posedge hclk);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd(IDX_PRESCALER_COUNT, 8'h7f);
    rd(IDX_MAIN_COUNT, 8'hff);
    rd(IDX_COUNT_STATUS_CONTROL, 8'h00);
    rd(IDX_UNMAPPED, 8'h00);
    hsize <= 3'h0;
    wr(IDX_MAIN_COUNT, 8'h55);
    hsize <= HSIZE_WORD;
    rd(IDX_MAIN_COUNT, 8'hff);
    pins(4'b0000);
  endtask
  task automatic t_event();
    wr(IDX_MAIN_COUNT, 8'h03);
    wr(IDX_COUNT_STATUS_CONTROL, 8'h08);
    pulse(8'h03);
    rd(IDX_MAIN_COUNT, 8'h00);
    rd(IDX_PRESCALER_COUNT, 8'h7c);
    rd(IDX_COUNT_STATUS_CONTROL, 8'h08);
    stop_mode <= 1'b1;
    pulse(8'h01);
    stop_mode <= 1'b0;
    rd(IDX_MAIN_COUNT, 8'hff);
    rd(IDX_COUNT_STATUS_CONTROL, 8'h88);
    wr(IDX_COUNT_STATUS_CONTROL, 8'hc8);
    pins(4'b0011);
    repeat (20) @(posedge hclk);
    rd(IDX_COUNT_STATUS_CONTROL, 8'hc8);
    wr(IDX_COUNT_STATUS_CONTROL, 8'h48);
    pins(4'b0000);
    wr(IDX_COUNT_STATUS_CONTROL, 8'h88);
    rd(IDX_COUNT_STATUS_CONTROL, 8'h88);
    pins(4'b0000);
    wr(IDX_COUNT_STATUS_CONTROL, 8'h08);
    wr(IDX_MAIN_COUNT, 8'h00);
    rd(IDX_COUNT_STATUS_CONTROL, 8'h88);
  endtask
  task automatic t_tap();
    wr(IDX_COUNT_STATUS_CONTROL, 8'h02);
    wr(IDX_MAIN_COUNT, 8'h10);
    pulse(8'h02);
    rd(IDX_MAIN_COUNT, 8'h10);
    rd(IDX_PRESCALER_COUNT, 8'h7f);
    wr(IDX_COUNT_STATUS_CONTROL, 8'h0a);
    pulse(8'h08);
    rd(IDX_PRESCALER_COUNT, 8'h77);
    rd(IDX_MAIN_COUNT, 8'h0e);
  endtask
  task automatic t_gated();
    wait_mode <= 1'b1;
    wr(IDX_COUNT_STATUS_CONTROL, 8'h10);
    wr(IDX_COUNT_STATUS_CONTROL, 8'h18);
    repeat (48) @(posedge hclk);
    rd(IDX_PRESCALER_COUNT, 8'h7f);
    hold_high <= 1'b1;
    repeat (60) @(posedge hclk);
    xfer(1'b0, IDX_PRESCALER_COUNT, 8'h00, v);
    chk_rng(v, 32'h0000_0078, 32'h0000_007b);
    hold_high <= 1'b0;
    wait_mode <= 1'b0;
  endtask
  task automatic t_output();
    wr(IDX_COUNT_STATUS_CONTROL, 8'h30);
    pins(4'b0100);
    wr(IDX_MAIN_COUNT, 8'h00);
    pins(4'b1100);
    wr(IDX_COUNT_STATUS_CONTROL, 8'h20);
    pins(4'b1100);
    wr(IDX_MAIN_COUNT, 8'h00);
    pins(4'b0100);
    wr(IDX_COUNT_STATUS_CONTROL, 8'h20);
    wr(IDX_COUNT_STATUS_CONTROL, 8'h28);
    repeat (120) @(posedge hclk);
    xfer(1'b0, IDX_PRESCALER_COUNT, 8'h00, v);
    chk_rng(v, 32'h0000_0073, 32'h0000_0076);
    stop_mode <= 1'b1;
    xfer(1'b0, IDX_PRESCALER_COUNT, 8'h00, v);
    repeat (40) @(posedge hclk);
    rd(IDX_PRESCALER_COUNT, v[7:0]);
    stop_mode <= 1'b0;
  endtask
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_event();
    t_tap();
    t_gated();
    t_output();
    test_done();
  end
  initial
  begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    test_done();
  end
endmodule // tb
